/* common/dmaer_pkg.sv */
// shared constants and types for the two-channel transfer controller
package dmaer_pkg;
  localparam int          NUM_CH          = 2;
  localparam int          ADDR_W          = 16;
  localparam int          CNT_W           = 16;
  // channel control register bits
  localparam int          CTL_SEL_LSB     = 0;
  localparam int          CTL_SEL_W       = 2;
  localparam int          CTL_REQ_BIT     = 2;
  localparam int          CTL_EN_BIT      = 3;
  localparam int          CTL_FWD_BIT     = 4;
  localparam int          CTL_W           = 8;
  localparam logic [7:0]  CTL_RESET       = 8'h00;
  // per-channel register block: stride and word offsets
  localparam logic [11:0] CH_STRIDE       = 12'h020;
  localparam logic [11:0] OFF_CTL         = 12'h000;
  localparam logic [11:0] OFF_SRC         = 12'h004;
  localparam logic [11:0] OFF_DST         = 12'h008;
  localparam logic [11:0] OFF_RELOAD      = 12'h00c;
  localparam logic [11:0] OFF_FWD_PTR     = 12'h010;
  localparam logic [11:0] OFF_COUNT       = 12'h014;
  localparam logic [11:0] OFF_DATA        = 12'h018;
  localparam int          FIFO_DEPTH      = 4;

  typedef struct packed {
    logic              src_is_fwd;
    logic [ADDR_W-1:0] fwd_ptr;
    logic [CNT_W-1:0]  count;
  } dmaer_chan_s;

  typedef struct packed {
    logic [0:0]        ch;
    logic [ADDR_W-1:0] addr;
  } dmaer_xfer_s;
endpackage

/* logic/dmaer_fifo.sv */
// small valid/ready fifo with parameter width and depth
module dmaer_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic             push;
  logic             pop;

  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* logic/dmaer_ctrl.sv */
// enable and request flag control for the two-channel transfer controller
//
// The placing of the registers and the APB slave port were left to the implementer.
module dmaer_ctrl #(
  parameter int DATA_W = 32,
  parameter int DEPTH  = dmaer_pkg::FIFO_DEPTH
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // request source lines, four per channel, from pins
  input  wire logic [3:0]  req_src_0,
  input  wire logic [3:0]  req_src_1,
  // transfer stream towards the memory bus
  output logic             xfer_valid,
  input  wire logic        xfer_ready,
  output logic      [DATA_W-1:0] xfer_data
);
  localparam int NCH = dmaer_pkg::NUM_CH;

  // software-visible state per channel
  logic [1:0]                   sel      [NCH];
  logic [NCH-1:0]               enable;
  logic [NCH-1:0]               request;
  logic [NCH-1:0]               fwd_src;
  logic [dmaer_pkg::ADDR_W-1:0] src_ptr  [NCH];
  logic [dmaer_pkg::ADDR_W-1:0] dst_ptr  [NCH];
  logic [dmaer_pkg::CNT_W-1:0]  reload   [NCH];
  dmaer_pkg::dmaer_chan_s       chan     [NCH];

  // request pin synchronisers and edge detection
  logic [3:0] src_meta [NCH];
  logic [3:0] src_sync [NCH];
  logic [3:0] src_prev [NCH];
  logic [NCH-1:0] req_event;

  // apb decode
  logic        wr_en;
  logic        rd_en;
  logic [0:0]  acc_ch;
  logic [11:0] acc_off;
  logic        acc_hit;
  logic [NCH-1:0] en_write;

  // transfer start, one channel per cycle
  logic [NCH-1:0] start;
  logic           fifo_in_ready;
  dmaer_pkg::dmaer_xfer_s next_xfer;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign acc_ch  = paddr[5];
  assign acc_off = paddr & (dmaer_pkg::CH_STRIDE - 12'h001);
  assign acc_hit = (paddr < 12'(NCH) * dmaer_pkg::CH_STRIDE) && (paddr[1:0] == 2'h0)
                   && (acc_off <= dmaer_pkg::OFF_DATA);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !acc_hit;

  // round-robin free fixed priority: channel 0 first
  always_comb begin
    start     = '0;
    next_xfer = '0;
    if (fifo_in_ready) begin
      if (enable[0] && request[0] && chan[0].count != '0) begin
        start[0] = 1'b1;
        next_xfer.ch   = 1'b0;
        next_xfer.addr = chan[0].fwd_ptr;
      end else if (enable[1] && request[1] && chan[1].count != '0) begin
        start[1] = 1'b1;
        next_xfer.ch   = 1'b1;
        next_xfer.addr = chan[1].fwd_ptr;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire logic [3:0] pins = (g == 0) ? req_src_0 : req_src_1;
      wire logic       sel_hit = wr_en && acc_hit && (acc_ch == 1'(g));

      assign en_write[g] = sel_hit && (acc_off == dmaer_pkg::OFF_CTL)
                           && pwdata[dmaer_pkg::CTL_EN_BIT];
      assign req_event[g] = src_sync[g][sel[g]] && !src_prev[g][sel[g]];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          src_meta[g] <= '0;
          src_sync[g] <= '0;
          src_prev[g] <= '0;
        end else begin
          src_meta[g] <= pins;
          src_sync[g] <= src_meta[g];
          src_prev[g] <= src_sync[g];
        end
      end

      // control fields written by software
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sel[g]     <= '0;
          fwd_src[g] <= 1'b0;
          enable[g]  <= 1'b0;
          src_ptr[g] <= '0;
          dst_ptr[g] <= '0;
          reload[g]  <= '0;
        end else begin
          if (sel_hit) begin
            case (acc_off)
              dmaer_pkg::OFF_CTL: begin
                sel[g]     <= pwdata[dmaer_pkg::CTL_SEL_LSB +: dmaer_pkg::CTL_SEL_W];
                fwd_src[g] <= pwdata[dmaer_pkg::CTL_FWD_BIT];
                enable[g]  <= pwdata[dmaer_pkg::CTL_EN_BIT];
              end
              dmaer_pkg::OFF_SRC:    src_ptr[g] <= pwdata[dmaer_pkg::ADDR_W-1:0];
              dmaer_pkg::OFF_DST:    dst_ptr[g] <= pwdata[dmaer_pkg::ADDR_W-1:0];
              dmaer_pkg::OFF_RELOAD: reload[g]  <= pwdata[dmaer_pkg::CNT_W-1:0];
              default: begin
              end
            endcase
          end
        end
      end

      // request flag: hardware set wins over any clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          request[g] <= 1'b0;
        end else if (req_event[g]) begin
          request[g] <= 1'b1;
        end else if (start[g]) begin
          request[g] <= 1'b0;
        end else if (sel_hit && acc_off == dmaer_pkg::OFF_CTL
                     && !pwdata[dmaer_pkg::CTL_REQ_BIT]) begin
          request[g] <= 1'b0;
        end
      end

      // forward pointer and counter
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          chan[g] <= '0;
        end else if (en_write[g]) begin
          chan[g].src_is_fwd <= pwdata[dmaer_pkg::CTL_FWD_BIT];
          chan[g].fwd_ptr    <= pwdata[dmaer_pkg::CTL_FWD_BIT] ? src_ptr[g] : dst_ptr[g];
          chan[g].count      <= reload[g];
        end else if (start[g]) begin
          chan[g].fwd_ptr <= chan[g].fwd_ptr + 1'b1;
          chan[g].count   <= chan[g].count - 1'b1;
        end
      end
    end
  endgenerate

  // read data from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= '0;
      // unmapped or unaligned reads return zero
      if (acc_hit) begin
      case (acc_off)
        dmaer_pkg::OFF_CTL: begin
          prdata[dmaer_pkg::CTL_SEL_LSB +: dmaer_pkg::CTL_SEL_W] <= sel[paddr[5]];
          prdata[dmaer_pkg::CTL_REQ_BIT] <= request[paddr[5]];
          prdata[dmaer_pkg::CTL_EN_BIT]  <= enable[paddr[5]];
          prdata[dmaer_pkg::CTL_FWD_BIT] <= fwd_src[paddr[5]];
        end
        dmaer_pkg::OFF_SRC:     prdata[dmaer_pkg::ADDR_W-1:0] <= src_ptr[paddr[5]];
        dmaer_pkg::OFF_DST:     prdata[dmaer_pkg::ADDR_W-1:0] <= dst_ptr[paddr[5]];
        dmaer_pkg::OFF_RELOAD:  prdata[dmaer_pkg::CNT_W-1:0]  <= reload[paddr[5]];
        dmaer_pkg::OFF_FWD_PTR: prdata[dmaer_pkg::ADDR_W-1:0] <= chan[paddr[5]].fwd_ptr;
        dmaer_pkg::OFF_COUNT:   prdata[dmaer_pkg::CNT_W-1:0]  <= chan[paddr[5]].count;
        default: begin
        end
      endcase
      end
    end
  end

  // transfer descriptors queue up towards the memory bus
  dmaer_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (|start),
    .in_ready  (fifo_in_ready),
    .in_data   (DATA_W'(next_xfer)),
    .out_valid (xfer_valid),
    .out_ready (xfer_ready),
    .out_data  (xfer_data)
  );

  logic unused_rd;
  assign unused_rd = rd_en;
endmodule

/* bench/dmaer_ctrl_monitor.sv */
// port checker for the transfer controller
module dmaer_ctrl_monitor #(
  parameter int DATA_W = 32
) (
  // apb
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // stream
  input wire logic              xfer_valid,
  input wire logic              xfer_ready,
  input wire logic [DATA_W-1:0] xfer_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic acc;
  assign acc = psel && penable;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_zero_wait: assert property (acc |-> pready) else $error("pready low in access");
  a_err_unmapped: assert property (acc && paddr >= 12'h040 |-> pslverr) else $error("no error");
  a_ok_mapped: assert property (acc && paddr < 12'h040 && paddr[1:0] == 2'h0 && paddr[4:0] <= 5'h18 |-> !pslverr)
    else $error("error on mapped");
  a_rd_unmapped: assert property (acc && !pwrite && paddr >= 12'h040 |-> prdata == 32'h0)
    else $error("unmapped read not 0");
  a_ctl_width: assert property (acc && !pwrite && paddr[4:0] == 5'h00 && paddr < 12'h040 |->
    prdata[31:8] == 24'h0) else $error("control read too wide");
  a_reset_idle: assert property ($rose(presetn) |-> !xfer_valid) else $error("stream busy");
  a_stall_hold: assert property (xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer_data))
    else $error("stream head moved");
  a_desc_form: assert property (xfer_valid |-> xfer_data[DATA_W-1:17] == '0) else $error("bad descriptor");
  c_xfer: cover property (xfer_valid && xfer_ready);
  c_stall: cover property (xfer_valid && !xfer_ready);
  c_err: cover property (acc && pslverr);
endmodule
bind dmaer_ctrl dmaer_ctrl_monitor #(.DATA_W(DATA_W)) u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .xfer_valid(xfer_valid),
  .xfer_ready(xfer_ready), .xfer_data(xfer_data));

/* bench/dmaer_far_model.sv */
// request sources and memory-side sink
module dmaer_far_model (
  // stream
  input wire logic        pclk,
  input wire logic        xfer_valid,
  input wire logic [31:0] xfer_data,
  output logic            xfer_ready,
  // request pins
  output logic [3:0]      req_src_0,
  output logic [3:0]      req_src_1
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        stall = 1'b1;
  logic [31:0] got[$];
  initial begin
    xfer_ready = 1'b0;
    req_src_0 = 4'h0;
    req_src_1 = 4'h0;
  end
  always @(posedge pclk) begin
    if (xfer_valid && xfer_ready) got.push_back(xfer_data);
    xfer_ready <= !stall;
  end
  // one rising edge, then room for sync and start
  task pulse(input int ch, input int b);
    @(posedge pclk);
    if (ch == 0) req_src_0[b] <= 1'b1;
    else req_src_1[b] <= 1'b1;
    repeat (2) @(posedge pclk);
    req_src_0 <= 4'h0;
    req_src_1 <= 4'h0;
    repeat (6) @(posedge pclk);
  endtask
endmodule

/* bench/tb.sv */
// register-level tests of the transfer controller
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, xfer_data, r;
  logic        pready, pslverr, xfer_valid, xfer_ready;
  logic [3:0]  req_src_0, req_src_1;
  logic [31:0] ex[5] = '{32'h1000, 32'h1000, 32'h1001, 32'h1002, 32'h12000};
  int          failures = 0, n_tests = 0, tn = 0;
  dmaer_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_src_0(req_src_0), .req_src_1(req_src_1), .xfer_valid(xfer_valid),
    .xfer_ready(xfer_ready), .xfer_data(xfer_data));
  dmaer_far_model far (.pclk(pclk), .xfer_valid(xfer_valid), .xfer_data(xfer_data),
    .xfer_ready(xfer_ready), .req_src_0(req_src_0), .req_src_1(req_src_1));
  initial forever #50 pclk = ~pclk;
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x); bus(0, a, 0); chk(r, x); endtask
  task wr(input logic [11:0] a, input logic [31:0] d); bus(1, a, d); endtask
  task done; tn++; $display("test %0d done", tn); endtask
  task print_verdict;
    $display("checks=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge pclk);
    failures++;
    print_verdict;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    rd(12'h000, 0);
    rd(12'h020, 0);
    bus(1, 12'h040, 32'hff); chk({31'h0, e}, 1);
    rd(12'h040, 0); done;
    wr(12'h020, 32'h01); wr(12'h020, 32'h01);
    far.pulse(1, 1); rd(12'h020, 32'h05);
    wr(12'h020, 32'h05); rd(12'h020, 32'h05);
    wr(12'h020, 32'h01); rd(12'h020, 32'h01); done;
    wr(12'h004, 32'h1000); wr(12'h00c, 32'h3); wr(12'h000, 32'h18);
    rd(12'h010, 32'h1000);
    rd(12'h014, 32'h3);
    rd(12'h000, 32'h18);
    far.pulse(0, 0); rd(12'h000, 32'h18);
    rd(12'h014, 32'h2);
    wr(12'h000, 32'h18); rd(12'h014, 32'h3);
    rd(12'h010, 32'h1000); done;
    repeat (3) far.pulse(0, 0);
    rd(12'h014, 0);
    far.pulse(0, 0); rd(12'h000, 32'h1c);
    wr(12'h028, 32'h2000); wr(12'h02c, 32'h1); wr(12'h020, 32'h09);
    far.pulse(1, 1); rd(12'h020, 32'h0d);
    far.stall <= 0;
    for (int i = 0; i < 60 && far.got.size() < 5; i++) @(posedge pclk);
    chk(32'(far.got.size()), 5);
    for (int i = 0; i < 5; i++) chk(far.got[i], ex[i]);
    rd(12'h020, 32'h09); done;
    print_verdict;
  end
endmodule
